// >>> core/arfts_pkg.sv
// constants and types shared by the converter result and sensor sequencing logic
// How it works
// - a finished code becomes readable in the result bytes only once the done flag is high.
// - single-ended codes are unsigned ten-bit values from ground (0x000) to full reference (0x3ff).
// - differential codes are two's complement from 0x200 (most negative) to 0x1ff (most positive).
// - the top result bit sits in the high byte and marks a negative differential result.
// - each result is split over a high byte and a low byte register.
// - with left adjust cleared the result is right adjusted in the two bytes.
// - the sensor buffer driver is on only while the applied channel selection picks the sensor; it settles in about 2 us.
// - changing left adjust reorders the result bytes at once, even during a conversion.
// - channel or reference changes written during a conversion apply only after it completes.
// - the done flag is set as soon as a conversion finishes and the result is stored.
package arfts_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_INPUT_SELECT = 8'h00;
   localparam logic [7:0] ADDR_CONTROL_FIRST = 8'h04;
   localparam logic [7:0] ADDR_RESULT_LOW = 8'h08;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
   localparam logic [7:0] ADDR_SENSOR_STATUS = 8'h18;
   // input select register fields
   localparam int REF_MSB = 7;
   localparam int REF_LSB = 6;
   localparam int LEFT_ADJUST_BIT = 5;
   localparam int CHAN_MSB = 4;
   localparam int CHAN_LSB = 0;
   localparam logic [4:0] CHAN_TEMP_SENSOR = 5'h0b;
   localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
   // control register fields
   localparam int START_BIT = 6;
   localparam int DONE_BIT = 4;
   localparam int DIFF_BIT = 0;
   // interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_SETTLED = 1;
   localparam int IRQ_WIDTH = 2;
   // sensor driver settling
   localparam int CLK_MHZ = 40;
   localparam int SETTLE_NS = 2000;
   localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_W = 7;
   typedef enum logic [1:0]
   {
      ARFTS_IDLE = 2'b00,
      ARFTS_BUSY = 2'b01
   } arfts_conv_e;
endpackage

// >>> core/arfts_core.sv
// result formatting, sensor driver sequencing and apb register file
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module arfts_core
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter core side
   output logic conv_start,
   output logic [4:0] conv_channel,
   output logic [1:0] conv_reference,
   output logic conv_differential,
   input wire logic conv_valid,
   input wire logic [9:0] conv_code,
   output logic sensor_driver_en,
   output logic irq
);
   logic [7:0] input_select;
   logic [4:0] act_channel;
   logic [1:0] act_reference;
   logic act_diff;
   logic diff_mode;
   logic [9:0] result_code;
   logic conversion_done_flag;
   logic [arfts_pkg::IRQ_WIDTH-1:0] irq_status;
   logic [arfts_pkg::IRQ_WIDTH-1:0] irq_mask;
   logic [arfts_pkg::SETTLE_W-1:0] settle_cnt;
   logic sensor_settled;
   logic start_pulse;
   arfts_pkg::arfts_conv_e state;
   arfts_pkg::arfts_conv_e next_state;

   wire wr_en = psel && penable && pwrite;
   wire rd_access = psel && penable && !pwrite;
   wire sel_in = paddr == arfts_pkg::ADDR_INPUT_SELECT;
   wire sel_ctl = paddr == arfts_pkg::ADDR_CONTROL_FIRST;
   wire sel_lo = paddr == arfts_pkg::ADDR_RESULT_LOW;
   wire sel_hi = paddr == arfts_pkg::ADDR_RESULT_HIGH;
   wire sel_st = paddr == arfts_pkg::ADDR_IRQ_STATUS;
   wire sel_mk = paddr == arfts_pkg::ADDR_IRQ_MASK;
   wire sel_ss = paddr == arfts_pkg::ADDR_SENSOR_STATUS;
   wire mapped = sel_in | sel_ctl | sel_lo | sel_hi | sel_st | sel_mk | sel_ss;
   wire busy = state == arfts_pkg::ARFTS_BUSY;
   wire left_adj = input_select[arfts_pkg::LEFT_ADJUST_BIT];
   wire sensor_picked = act_channel == arfts_pkg::CHAN_TEMP_SENSOR;
   wire finish = busy && conv_valid;
   wire settle_done =
      settle_cnt == arfts_pkg::SETTLE_W'(arfts_pkg::SETTLE_CYCLES);
   wire [arfts_pkg::IRQ_WIDTH-1:0] irq_events =
      {sensor_picked && !sensor_settled && settle_done, finish};

   // byte views follow left adjust combinationally, so a change applies at once
   wire [7:0] low_byte = left_adj ? {result_code[1:0], 6'h00}
                                  : result_code[7:0];
   wire [7:0] high_byte = left_adj ? result_code[9:2]
                                   : {6'h00, result_code[9:8]};

   wire [7:0] ctl_view = {1'b0, busy, 1'b0, conversion_done_flag,
                          3'h0, diff_mode};
   wire [31:0] rd_mux =
      sel_in ? {24'h0, input_select} :
      sel_ctl ? {24'h0, ctl_view} :
      sel_lo ? {24'h0, low_byte} :
      sel_hi ? {24'h0, high_byte} :
      sel_st ? {30'h0, irq_status} :
      sel_mk ? {30'h0, irq_mask} :
      sel_ss ? {30'h0, sensor_settled, sensor_driver_en} : 32'h0;

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign irq = |(irq_status & irq_mask);
   assign conv_channel = act_channel;
   assign conv_reference = act_reference;
   assign conv_differential = act_diff;
   assign conv_start = start_pulse;
   assign sensor_driver_en = sensor_picked;
   assign start_pulse = wr_en && sel_ctl && !busy
                        && pwdata[arfts_pkg::START_BIT];

   always_comb
   begin
      next_state = state;
      case (state)
         arfts_pkg::ARFTS_IDLE:
            if (start_pulse)
               next_state = arfts_pkg::ARFTS_BUSY;
         arfts_pkg::ARFTS_BUSY:
            if (conv_valid)
               next_state = arfts_pkg::ARFTS_IDLE;
         default:
            next_state = arfts_pkg::ARFTS_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= arfts_pkg::ARFTS_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         input_select <= arfts_pkg::INPUT_SELECT_RESET;
         diff_mode <= 1'b0;
         irq_mask <= '0;
      end
      else if (wr_en)
      begin
         if (sel_in)
            input_select <= pwdata[7:0];
         if (sel_ctl)
            diff_mode <= pwdata[arfts_pkg::DIFF_BIT];
         if (sel_mk)
            irq_mask <= pwdata[arfts_pkg::IRQ_WIDTH-1:0];
      end
   end

   // selections reach the core only while no conversion runs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         act_channel <= '0;
         act_reference <= '0;
         act_diff <= 1'b0;
      end
      else if (!busy)
      begin
         act_channel <= input_select[arfts_pkg::CHAN_MSB:arfts_pkg::CHAN_LSB];
         act_reference <= input_select[arfts_pkg::REF_MSB:arfts_pkg::REF_LSB];
         // a start write carries its own diff bit, so take it at once
         act_diff <= (wr_en && sel_ctl) ? pwdata[arfts_pkg::DIFF_BIT]
                                        : diff_mode;
      end
   end

   // code stored raw: unsigned or two's complement alike, same bits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         result_code <= '0;
      else if (finish)
         result_code <= conv_code;
   end

   // done flag set with the store; set wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         conversion_done_flag <= 1'b0;
      else if (finish)
         conversion_done_flag <= 1'b1;
      else if (wr_en && sel_ctl && pwdata[arfts_pkg::DONE_BIT])
         conversion_done_flag <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status <= '0;
      else if (wr_en && sel_st)
         irq_status <= (irq_status & ~pwdata[arfts_pkg::IRQ_WIDTH-1:0])
                       | irq_events;
      else
         irq_status <= irq_status | irq_events;
   end

   // driver settling timer restarts whenever the sensor is deselected
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         settle_cnt <= '0;
         sensor_settled <= 1'b0;
      end
      else if (!sensor_picked)
      begin
         settle_cnt <= '0;
         sensor_settled <= 1'b0;
      end
      else if (settle_done)
         sensor_settled <= 1'b1;
      else
         settle_cnt <= settle_cnt + 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (psel && !penable && !pwrite)
         prdata <= rd_mux;
   end

   wire unused_rd = rd_access;

   a_done_after_store: assert property (@(posedge pclk) disable iff (!presetn)
      finish |=> conversion_done_flag && result_code == $past(conv_code))
      else $error("done flag or result missing after conversion");
   a_result_stable: assert property (@(posedge pclk) disable iff (!presetn)
      busy && !conv_valid |=> $stable(result_code))
      else $error("result changed before conversion finished");
   a_left_layout: assert property (@(posedge pclk) disable iff (!presetn)
      left_adj |-> high_byte == result_code[9:2]
                   && low_byte[5:0] == 6'h00)
      else $error("left adjusted layout wrong");
   a_right_layout: assert property (@(posedge pclk) disable iff (!presetn)
      !left_adj |-> low_byte == result_code[7:0]
                    && high_byte == {6'h00, result_code[9:8]})
      else $error("right adjusted layout wrong");
   a_sign_in_high: assert property (@(posedge pclk) disable iff (!presetn)
      left_adj |-> high_byte[7] == result_code[9])
      else $error("sign bit not in high byte");
   a_sel_held_busy: assert property (@(posedge pclk) disable iff (!presetn)
      busy && $past(busy) |-> $stable(act_channel) && $stable(act_reference))
      else $error("selection changed during conversion");
   a_driver_follow: assert property (@(posedge pclk) disable iff (!presetn)
      sensor_driver_en == (act_channel == arfts_pkg::CHAN_TEMP_SENSOR))
      else $error("driver enable does not follow selection");
   a_settle_time: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(sensor_driver_en) |-> !sensor_settled [*8])
      else $error("sensor settled too early");
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(conversion_done_flag) && irq_mask[arfts_pkg::IRQ_DONE] |-> irq)
      else $error("interrupt missing on done");

   // result storage and byte views
   a_result_code_held: assert property (@(posedge pclk)
      disable iff (!presetn)
      !finish |=> $stable(result_code))
      else $error("result changed without a finished conversion");

   a_low_read_view: assert property (@(posedge pclk)
      disable iff (!presetn)
      psel && !penable && !pwrite && sel_lo |=> prdata == {24'h0, $past(low_byte)})
      else $error("low byte read wrong");

   a_high_read_view: assert property (@(posedge pclk)
      disable iff (!presetn)
      psel && !penable && !pwrite && sel_hi |=> prdata == {24'h0, $past(high_byte)})
      else $error("high byte read wrong");

   a_unmapped_zero: assert property (@(posedge pclk)
      disable iff (!presetn)
      psel && !penable && !pwrite && !mapped |=> prdata == 32'h0)
      else $error("unmapped read not zero");

   a_prdata_hold: assert property (@(posedge pclk)
      disable iff (!presetn)
      !(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data changed outside a read setup");

   a_sign_right: assert property (@(posedge pclk)
      disable iff (!presetn)
      !left_adj |-> high_byte[1] == result_code[9])
      else $error("sign bit misplaced when right adjusted");

   a_left_low_bits: assert property (@(posedge pclk)
      disable iff (!presetn)
      left_adj |-> low_byte[7:6] == result_code[1:0])
      else $error("left adjusted low bits wrong");

   // selection handling around a conversion
   a_diff_frozen: assert property (@(posedge pclk)
      disable iff (!presetn)
      busy && $past(busy) |-> $stable(act_diff))
      else $error("differential select changed during conversion");

   a_sel_applied_idle: assert property (@(posedge pclk)
      disable iff (!presetn)
      !$past(busy) |-> act_channel == $past(input_select[4:0]))
      else $error("channel not applied while idle");

   a_start_idle_only: assert property (@(posedge pclk)
      disable iff (!presetn)
      conv_start |-> !busy)
      else $error("start issued while busy");

   a_busy_after_start: assert property (@(posedge pclk)
      disable iff (!presetn)
      conv_start |=> busy)
      else $error("not busy after start");

   // done flag and interrupt status
   a_done_clear: assert property (@(posedge pclk)
      disable iff (!presetn)
      !finish && wr_en && sel_ctl && pwdata[arfts_pkg::DONE_BIT]
      |=> !conversion_done_flag)
      else $error("done flag not cleared by write one");

   a_done_set_wins: assert property (@(posedge pclk)
      disable iff (!presetn)
      finish && wr_en && sel_ctl |=> conversion_done_flag)
      else $error("clear won over a finishing conversion");

   a_irq_done_event: assert property (@(posedge pclk)
      disable iff (!presetn)
      finish |=> irq_status[arfts_pkg::IRQ_DONE])
      else $error("done event not recorded");

   a_irq_masked_off: assert property (@(posedge pclk)
      disable iff (!presetn)
      irq_mask == '0 |-> !irq)
      else $error("interrupt high with all sources masked");

   // sensor driver settling
   a_driver_off: assert property (@(posedge pclk)
      disable iff (!presetn)
      !sensor_driver_en |=> !sensor_settled)
      else $error("settled kept with driver off");

   a_settle_count: assert property (@(posedge pclk)
      disable iff (!presetn)
      sensor_settled |-> settle_done)
      else $error("settled before the full count");

   a_settled_event: assert property (@(posedge pclk)
      disable iff (!presetn)
      $rose(sensor_settled) |-> irq_status[arfts_pkg::IRQ_SETTLED])
      else $error("settle event not recorded");

   c_diff_result: cover property (@(posedge pclk) disable iff (!presetn)
      finish && act_diff);
   c_late_select: cover property (@(posedge pclk) disable iff (!presetn)
      busy && wr_en && sel_in);

   c_conversion: cover property (@(posedge pclk) disable iff (!presetn)
      start_pulse ##[1:50] finish);
   c_adjust_flip: cover property (@(posedge pclk) disable iff (!presetn)
      conversion_done_flag && $changed(left_adj));
   c_sensor_ready: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(sensor_settled));
endmodule

// >>> sim/arfts_conv_model.sv
// converter core stand-in answering each start with a code
`timescale 1ns/1ps
module arfts_conv_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic conv_start,
   input wire logic [9:0] code,
   input wire logic [4:0] lat,
   output logic conv_valid,
   output logic [9:0] conv_code
);
   logic [5:0] cnt;
   logic [9:0] last;
   // code shown only in its valid cycle, inverted otherwise
   assign conv_code = conv_valid ? last : ~last;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cnt <= '0;
         conv_valid <= 1'b0;
         last <= '0;
      end
      else
      begin
         conv_valid <= (cnt == 6'h01);
         if (conv_start)
         begin
            cnt <= {1'b0, lat} + 6'h01;
            last <= code;
         end
         else if (cnt != 6'h00)
            cnt <= cnt - 6'h01;
      end
endmodule

// >>> sim/tb_top.sv
// self-checking bench for result formatting and sensor sequencing
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, ex;
   logic pready, pslverr, conv_start, conv_valid, conv_differential;
   logic sensor_driver_en, irq, la, d;
   logic [4:0] conv_channel, lat = 1;
   logic [1:0] conv_reference;
   logic [9:0] conv_code, code = 0, c;
   logic [15:0] f;
   logic [9:0] tc [6] = '{10'h270, 10'h029, 10'h3ff, 10'h000, 10'h200, 10'h1ff};
   logic [31:0] exq [$];
   int n_fail = 0, tests_run = 0;
   integer seed = 32'hdb17b40a;
   arfts_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv_start(conv_start), .conv_channel(conv_channel),
      .conv_reference(conv_reference), .conv_differential(conv_differential),
      .conv_valid(conv_valid), .conv_code(conv_code),
      .sensor_driver_en(sensor_driver_en), .irq(irq));
   arfts_conv_model core (.pclk(pclk), .presetn(presetn),
      .conv_start(conv_start), .code(code), .lat(lat),
      .conv_valid(conv_valid), .conv_code(conv_code));
   initial
      forever #12.5 pclk = ~pclk;
   function automatic logic [15:0] fmt(input logic [9:0] v, input logic l);
      return l ? {v, 6'h00} : {6'h00, v};
   endfunction
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, input logic err);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50)
      begin
         @(posedge pclk);
         k++;
      end
      if (k >= 50)
         n_fail++;
      `CHK("pslverr", err, pslverr)
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      xfer(1'b1, a, wd, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exq.push_back(e);
      xfer(1'b0, a, 32'h0, a > arfts_pkg::ADDR_SENSOR_STATUS);
   endtask
   task automatic wait_irq;
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 500)
      begin
         @(posedge pclk);
         k++;
      end
      `CHK("irq", 1'b1, irq)
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // each read answer is matched against the oldest noted value
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         ex = exq.pop_front();
         `CHK("prdata", ex, prdata)
      end
   initial
   begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      summarize;
   end
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(arfts_pkg::ADDR_INPUT_SELECT, 32'h0);
      rd(8'h1c, 32'h0);
      wr(arfts_pkg::ADDR_IRQ_MASK, 32'h3);
      for (int i = 0; i < 10; i++)
      begin
         c = i < 6 ? tc[i] : 10'($random(seed));
         la = 1'($random(seed));
         d = 1'($random(seed));
         lat <= 5'(($random(seed) & 15) + 1);
         code <= c;
         wr(arfts_pkg::ADDR_INPUT_SELECT, {24'h0, 2'b11, la, 5'h02});
         wr(arfts_pkg::ADDR_CONTROL_FIRST, {31'h20, d});
         `CHK("diff", d, conv_differential)
         wait_irq;
         rd(arfts_pkg::ADDR_CONTROL_FIRST, {31'h08, d});
         f = fmt(c, la);
         rd(arfts_pkg::ADDR_RESULT_LOW, {24'h0, f[7:0]});
         rd(arfts_pkg::ADDR_RESULT_HIGH, {24'h0, f[15:8]});
         f = fmt(c, !la);
         wr(arfts_pkg::ADDR_INPUT_SELECT, {24'h0, 2'b11, !la, 5'h02});
         rd(arfts_pkg::ADDR_RESULT_LOW, {24'h0, f[7:0]});
         rd(arfts_pkg::ADDR_RESULT_HIGH, {24'h0, f[15:8]});
         wr(arfts_pkg::ADDR_CONTROL_FIRST, {31'h08, d});
         wr(arfts_pkg::ADDR_IRQ_STATUS, 32'h1);
         `CHK("irq", 1'b0, irq)
      end
      lat <= 5'd30;
      code <= 10'h155;
      wr(arfts_pkg::ADDR_INPUT_SELECT, 32'h03);
      wr(arfts_pkg::ADDR_CONTROL_FIRST, 32'h40);
      // sensor and 2.56 V reference picked just after the start
      wr(arfts_pkg::ADDR_INPUT_SELECT, 32'hcb);
      `CHK("chan", 5'h03, conv_channel)
      `CHK("ref", 2'b00, conv_reference)
      `CHK("drv", 1'b0, sensor_driver_en)
      rd(arfts_pkg::ADDR_CONTROL_FIRST, 32'h40);
      rd(arfts_pkg::ADDR_RESULT_LOW, {24'h0, c[7:0]});
      wait_irq;
      @(posedge pclk);
      `CHK("chan", 5'h0b, conv_channel)
      `CHK("ref", 2'b11, conv_reference)
      `CHK("drv", 1'b1, sensor_driver_en)
      rd(arfts_pkg::ADDR_RESULT_LOW, 32'h55);
      rd(arfts_pkg::ADDR_SENSOR_STATUS, 32'h1);
      wr(arfts_pkg::ADDR_IRQ_STATUS, 32'h1);
      wr(arfts_pkg::ADDR_IRQ_MASK, 32'h2);
      repeat (arfts_pkg::SETTLE_CYCLES) @(posedge pclk);
      rd(arfts_pkg::ADDR_SENSOR_STATUS, 32'h3);
      `CHK("irq", 1'b1, irq)
      wr(arfts_pkg::ADDR_IRQ_MASK, 32'h1);
      `CHK("irq", 1'b0, irq)
      wr(arfts_pkg::ADDR_IRQ_STATUS, 32'h2);
      wr(arfts_pkg::ADDR_IRQ_MASK, 32'h3);
      `CHK("irq", 1'b0, irq)
      wr(arfts_pkg::ADDR_INPUT_SELECT, 32'h02);
      @(posedge pclk);
      `CHK("drv", 1'b0, sensor_driver_en)
      summarize;
   end
endmodule
